// ### rtl/rsnd_host.sv
// Host end: fetches, decodes and plans access to the select bit
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// Summary of operation
// - Bit 31 flags select bit present
// - Bit 30 inverts select value meaning
// - Bit 29 reserved, reads zero, ignored
// - Bit 28: addressed or direct access
// - Bit 27: local address byte 0/1
// - Byte-1 placement never with 8-bit addressing
// - Bits 26-24 give bit position
// - Bits 23-16 local address when addressed
// - Bits 23-20 flag 8D,8S,4D,4S modes
// - Bits 19-16 dummy count for flagged modes
// - Single-rate single-wire uses no dummies
// - Cleared flag means only count unsupported
// - Bits 15-8 read opcode, 00h none
// - Bits 7-0 write opcode, 00h none
module rsnd_host
  import rsnd_pkg::*;
(
  input  wire logic        mclk,   // 40 MHz clock
  input  wire logic        reset,  // Async reset, high
  input  wire logic        ce,     // Clock enable
  rsnd_if.host             lnk,    // Descriptor link
  input  wire logic [1:0]  addr,   // Register index
  input  wire logic [31:0] wdata,  // Write data
  input  wire logic        wr,     // Write strobe
  input  wire logic        rd,     // Read strobe
  output logic [31:0]      rdata   // Read data, cycle after rd
);
  import rsnd_pkg::*;

  typedef enum logic [1:0] {
    RSND_IDLE = 2'b00,
    RSND_WAIT = 2'b01
  } rsnd_st_t;

  typedef struct packed {
    rsnd_st_t    st;
    logic        req;
    logic        have;
    logic [31:0] desc;
    logic        dbl;
    rsnd_mode_t  mode;
    logic [31:0] rdata;
  } rsnd_hst_t;

  rsnd_hst_t s_q;
  rsnd_hst_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Field pickers: each descriptor field but bit 29 has one here; mode_flagged reads the mode flag bits directly
  function automatic logic avail_of(input logic [31:0] d);
    return d[AVAIL_BIT];
  endfunction

  function automatic logic pol_of(input logic [31:0] d);
    return d[POL_BIT];
  endfunction

  function automatic logic addrd_of(input logic [31:0] d);
    return d[ADDRD_BIT];
  endfunction

  function automatic logic byte1_of(input logic [31:0] d);
    return d[BYTE1_BIT];
  endfunction

  function automatic logic [2:0] pos_of(input logic [31:0] d);
    return d[POS_HI:POS_LO];
  endfunction

  function automatic logic [7:0] laddr_of(input logic [31:0] d);
    return d[LADDR_HI:LADDR_LO];
  endfunction

  function automatic logic [3:0] flags_of(input logic [31:0] d);
    return d[FLAG_8D:FLAG_4S];
  endfunction

  function automatic logic [3:0] dummy_of(input logic [31:0] d);
    return d[DUMMY_HI:DUMMY_LO];
  endfunction

  function automatic logic [7:0] rdop_of(input logic [31:0] d);
    return d[RDOP_HI:RDOP_LO];
  endfunction

  function automatic logic [7:0] wrop_of(input logic [31:0] d);
    return d[WROP_HI:WROP_LO];
  endfunction

  // Whether the chosen mode is flagged for the reported dummy count;
  // single-wire single-rate needs no flag since it never uses dummies
  function automatic logic mode_flagged(input logic [31:0] d,
                                        input rsnd_mode_t  m);
    logic ok;
    ok = 1'b0;
    unique case (m)
      RSND_M1S: ok = 1'b1;
      RSND_M4S: ok = d[FLAG_4S];
      RSND_M4D: ok = d[FLAG_4D];
      RSND_M8S: ok = d[FLAG_8S];
      RSND_M8D: ok = d[FLAG_8D];
      default:  ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Dummies to insert for the chosen mode
  function automatic logic [3:0] mode_dummies(input logic [31:0] d,
                                              input rsnd_mode_t  m);
    return (m == RSND_M1S) ? 4'h0 : dummy_of(d);
  endfunction

  // Command address with the local address in the lane bit 27 picks
  function automatic logic [31:0] cmd_addr(input logic [31:0] d);
    logic [31:0] a;
    a = ZERO32;
    if (addrd_of(d)) begin
      if (byte1_of(d)) begin
        a[CA_B1_HI:CA_B1_LO] = laddr_of(d);
      end else begin
        a[CA_B0_HI:CA_B0_LO] = laddr_of(d);
      end
    end
    return a;
  endfunction

  // Plan summary; bit 29 is never consulted, so a future use is harmless
  function automatic logic [31:0] access_info(input logic [31:0] d,
                                              input logic        dbl,
                                              input rsnd_mode_t  m);
    logic [31:0] r;
    r = ZERO32;
    r[ACC_AVAIL]             = avail_of(d);
    r[ACC_POL]               = pol_of(d);
    r[ACC_ADDRD]             = addrd_of(d);
    r[ACC_BYTE1]             = byte1_of(d);
    r[ACC_POS_HI:ACC_POS_LO] = pos_of(d);
    // No access is planned without the flag and a nonzero opcode
    r[ACC_RDOK] = avail_of(d) && (rdop_of(d) != OP_NONE);
    r[ACC_WROK] = avail_of(d) && (wrop_of(d) != OP_NONE);
    r[ACC_WVAL] = dbl ^ pol_of(d);
    if (!addrd_of(d)) begin
      r[ACC_FLG_HI:ACC_FLG_LO]   = flags_of(d);
      // A cleared flag is "not with this count", not "absent"
      r[ACC_FLAGGED]             = mode_flagged(d, m);
      r[ACC_MDMY_HI:ACC_MDMY_LO] = mode_dummies(d, m);
    end
    r[ACC_RDMY_HI:ACC_RDMY_LO] = dummy_of(d);
    return r;
  endfunction

  // Control readback: busy while a fetch waits, have once a word arrived
  function automatic logic [31:0] status_word(input rsnd_hst_t s);
    logic [31:0] r;
    r = ZERO32;
    r[STS_DBL]             = s.dbl;
    r[STS_MD_HI:STS_MD_LO] = s.mode;
    r[STS_BUSY]            = (s.st == RSND_WAIT);
    r[STS_HAVE]            = s.have;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.req = 1'b0;
    unique case (s_q.st)
      RSND_IDLE: begin
        if (wr && addr == REG_CTRL && wdata[CTL_START]) begin
          s_d.req = 1'b1;
          s_d.st  = RSND_WAIT;
        end
      end
      RSND_WAIT: begin
        if (lnk.vld) begin
          s_d.desc = lnk.word;
          s_d.have = 1'b1;
          s_d.st   = RSND_IDLE;
        end
      end
      default: s_d.st = RSND_IDLE;
    endcase
    if (wr && addr == REG_CTRL) begin
      s_d.dbl  = wdata[CTL_DBL];
      s_d.mode = rsnd_mode_t'(wdata[CTL_MD_HI:CTL_MD_LO]);
    end
    s_d.rdata = ZERO32;
    if (rd) begin
      unique case (addr)
        REG_DESC:   s_d.rdata = s_q.desc;
        REG_ACCESS: s_d.rdata = access_info(s_q.desc, s_q.dbl, s_q.mode);
        REG_CADDR:  s_d.rdata = cmd_addr(s_q.desc);
        REG_CTRL:   s_d.rdata = status_word(s_q);
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign lnk.req = s_q.req;
  assign rdata   = s_q.rdata;
endmodule // rsnd_host

// ### rtl/rsnd_pkg.sv
// Shared constants for the rate select non-volatile descriptor ends
package rsnd_pkg;
  // Descriptor field positions
  localparam int unsigned AVAIL_BIT  = 31;
  localparam int unsigned POL_BIT    = 30;
  localparam int unsigned RSVD_BIT   = 29;
  localparam int unsigned ADDRD_BIT  = 28;
  localparam int unsigned BYTE1_BIT  = 27;
  localparam int unsigned POS_HI     = 26;
  localparam int unsigned POS_LO     = 24;
  localparam int unsigned LADDR_HI   = 23;
  localparam int unsigned LADDR_LO   = 16;
  localparam int unsigned FLAG_8D    = 23;
  localparam int unsigned FLAG_8S    = 22;
  localparam int unsigned FLAG_4D    = 21;
  localparam int unsigned FLAG_4S    = 20;
  localparam int unsigned DUMMY_HI   = 19;
  localparam int unsigned DUMMY_LO   = 16;
  localparam int unsigned RDOP_HI    = 15;
  localparam int unsigned RDOP_LO    = 8;
  localparam int unsigned WROP_HI    = 7;
  localparam int unsigned WROP_LO    = 0;
  localparam logic [7:0]  OP_NONE    = 8'h00;
  localparam logic        RSVD_VAL   = 1'b0;
  // Address width of the flash register space
  typedef enum logic [1:0] {
    RSND_AW8  = 2'h0,
    RSND_AW24 = 2'h1,
    RSND_AW32 = 2'h2
  } rsnd_aw_t;
  // Transfer modes a command may use
  typedef enum logic [2:0] {
    RSND_M1S = 3'h0,
    RSND_M4S = 3'h1,
    RSND_M4D = 3'h2,
    RSND_M8S = 3'h3,
    RSND_M8D = 3'h4
  } rsnd_mode_t;
  // Host register indices and control bits
  localparam logic [1:0] REG_DESC   = 2'h0;
  localparam logic [1:0] REG_ACCESS = 2'h1;
  localparam logic [1:0] REG_CADDR  = 2'h2;
  localparam logic [1:0] REG_CTRL   = 2'h3;
  localparam int unsigned CTL_START = 0;
  localparam int unsigned CTL_DBL   = 1;
  localparam int unsigned CTL_MD_LO = 2;
  localparam int unsigned CTL_MD_HI = 4;
  // Access plan register layout
  localparam int unsigned ACC_AVAIL   = 0;
  localparam int unsigned ACC_POL     = 1;
  localparam int unsigned ACC_ADDRD   = 2;
  localparam int unsigned ACC_BYTE1   = 3;
  localparam int unsigned ACC_POS_LO  = 4;
  localparam int unsigned ACC_POS_HI  = 6;
  localparam int unsigned ACC_RDOK    = 7;
  localparam int unsigned ACC_WROK    = 8;
  localparam int unsigned ACC_WVAL    = 9;
  localparam int unsigned ACC_FLG_LO  = 10;
  localparam int unsigned ACC_FLG_HI  = 13;
  localparam int unsigned ACC_RDMY_LO = 14;
  localparam int unsigned ACC_RDMY_HI = 17;
  localparam int unsigned ACC_MDMY_LO = 18;
  localparam int unsigned ACC_MDMY_HI = 21;
  localparam int unsigned ACC_FLAGGED = 22;
  // Command address byte lanes
  localparam int unsigned CA_B0_LO    = 0;
  localparam int unsigned CA_B0_HI    = 7;
  localparam int unsigned CA_B1_LO    = 8;
  localparam int unsigned CA_B1_HI    = 15;
  // Control readback layout
  localparam int unsigned STS_DBL     = 0;
  localparam int unsigned STS_MD_LO   = 1;
  localparam int unsigned STS_MD_HI   = 3;
  localparam int unsigned STS_BUSY    = 4;
  localparam int unsigned STS_HAVE    = 5;
  localparam logic [31:0] ZERO32    = 32'h0000_0000;
endpackage

// ### rtl/rsnd_if.sv
// Descriptor fetch link between flash end and host end
`timescale 1ns/100ps
interface rsnd_if;
  logic        req;    // Host asks for the descriptor word
  logic        vld;    // Device answers with the word
  logic [31:0] word;   // Descriptor word
  modport dev  (input req, output vld, output word);
  modport host (output req, input vld, input word);
endinterface

// ### rtl/rsnd_dev.sv
// Flash end: builds the descriptor and applies the select bit
`timescale 1ns/100ps
module rsnd_dev
  import rsnd_pkg::*;
(
  input  wire logic             mclk,        // 40 MHz clock
  input  wire logic             reset,       // Async reset, high
  input  wire logic             ce,          // Clock enable
  rsnd_if.dev                   lnk,         // Descriptor link
  input  wire logic             present,     // Select bit exists
  input  wire logic             inverted,    // Select bit polarity
  input  wire logic             addressed,   // Access uses address
  input  wire logic             byte1,       // Address in byte 1
  input  wire rsnd_pkg::rsnd_aw_t aw,        // Register address width
  input  wire logic [2:0]       bit_pos,     // Select bit position
  input  wire logic [7:0]       local_addr,  // Register local address
  input  wire logic [3:0]       mode_flags,  // 8D,8S,4D,4S flags
  input  wire logic [3:0]       dummy,       // Reported dummy count
  input  wire logic [7:0]       rd_op,       // Read opcode
  input  wire logic [7:0]       wr_op,       // Write opcode
  input  wire logic             nv_sel,      // Stored select value
  input  wire rsnd_pkg::rsnd_mode_t cmd_mode,// Mode of current cmd
  output logic                  double_rate, // Effective rate is double
  output logic [3:0]            dummy_used   // Dummies for cmd_mode
);
  import rsnd_pkg::*;

  typedef struct packed {
    logic        vld;
    logic [31:0] word;
    logic        dbl;
    logic [3:0]  dmy;
  } rsnd_dst_t;

  rsnd_dst_t s_q;
  rsnd_dst_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] encode();
    logic [31:0] w;
    w = ZERO32;
    w[AVAIL_BIT] = present;
    w[POL_BIT]   = inverted;
    w[RSVD_BIT]  = RSVD_VAL;
    w[ADDRD_BIT] = addressed;
    // Byte-1 placement is meaningless with an 8-bit address space
    w[BYTE1_BIT] = byte1 && (aw != RSND_AW8);
    w[POS_HI:POS_LO] = bit_pos;
    if (addressed) begin
      w[LADDR_HI:LADDR_LO] = local_addr;
    end else begin
      w[FLAG_8D:FLAG_4S]   = mode_flags;
      w[DUMMY_HI:DUMMY_LO] = dummy;
    end
    w[RDOP_HI:RDOP_LO] = rd_op;
    w[WROP_HI:WROP_LO] = wr_op;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.vld = lnk.req;
    if (lnk.req) begin
      s_d.word = encode();
    end
    s_d.dbl = nv_sel ^ inverted;
    // Single-wire single-rate never inserts dummies
    s_d.dmy = (cmd_mode == RSND_M1S) ? 4'h0 : dummy;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign lnk.vld     = s_q.vld;
  assign lnk.word    = s_q.word;
  assign double_rate = s_q.dbl;
  assign dummy_used  = s_q.dmy;
endmodule // rsnd_dev

// ### test/rsnd_asserts.sv
// Link checker for the descriptor fetch between both ends
`timescale 1ns/100ps
module rsnd_asserts
  import rsnd_pkg::*;
(
  input wire logic        mclk,  // Clock
  input wire logic        reset, // Async reset, high
  input wire logic        ce,    // Clock enable
  input wire logic        req,   // Fetch request
  input wire logic        vld,   // Descriptor answer
  input wire logic [31:0] word   // Descriptor word
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  property p_answer; req && ce |=> vld; endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered next cycle");
  // A frozen answer may stand while ce is low; only its start needs a cause
  property p_cause; $rose(vld) |-> $past(req) && $past(ce); endproperty
  a_cause: assert property (p_cause)
    else $error("answer without request");
  property p_vld_pulse; vld && ce |=> !vld; endproperty
  a_vld_pulse: assert property (p_vld_pulse)
    else $error("answer longer than one cycle");
  property p_req_pulse; req && ce |=> !req; endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("request longer than one cycle");
  property p_rsvd; vld |-> word[RSVD_BIT] == RSVD_VAL; endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit set");
  // Word must only move when an answer is given
  property p_hold; !vld |-> $stable(word); endproperty
  a_hold: assert property (p_hold)
    else $error("word changed without answer");
  property p_no_overlap; req |-> !vld; endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("request while answer pending");
  property p_release; $fell(reset) |-> !req && !vld; endproperty
  a_release: assert property (p_release)
    else $error("link busy at reset release");
  c_fetch: cover property (req ##1 vld);
  c_addr: cover property (vld && word[ADDRD_BIT]);
  c_direct: cover property (vld && !word[ADDRD_BIT]);
endmodule // rsnd_asserts

// ### test/rate_select_nv_descriptor_tb.sv
// Bench driving both ends of the descriptor link
`timescale 1ns/100ps
module rate_select_nv_descriptor_tb;
  import rsnd_pkg::*;
  logic        mclk, reset, present, inverted, addressed, byte1;
  logic        nv_sel, wr, rd, double_rate, ce;
  rsnd_aw_t    aw;
  rsnd_mode_t  cmd_mode;
  logic [2:0]  bit_pos;
  logic [7:0]  local_addr, rd_op, wr_op;
  logic [3:0]  mode_flags, dummy, dummy_used;
  logic [1:0]  addr;
  logic [31:0] wdata, rdata;
  int          fails = 0, checks_done = 0, cyc = 0;
  rsnd_if lnk();
  rsnd_dev u_rsnd_dev(.mclk, .reset, .ce, .lnk(lnk), .present,
    .inverted, .addressed, .byte1, .aw, .bit_pos, .local_addr, .mode_flags,
    .dummy, .rd_op, .wr_op, .nv_sel, .cmd_mode, .double_rate, .dummy_used);
  rsnd_host u_rsnd_host(.mclk, .reset, .ce, .lnk(lnk), .addr, .wdata,
    .wr, .rd, .rdata);
  rsnd_asserts u_rsnd_asserts(.mclk, .reset, .ce, .req(lnk.req),
    .vld(lnk.vld), .word(lnk.word));
  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // A hung fetch must still reach the verdict
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      final_report;
    end
  end
  task final_report;
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task wreg(input logic [1:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [1:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a; rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task fetch(input logic [31:0] e);
    int n;
    logic [31:0] d;
    n = 0;
    wreg(REG_CTRL, 32'h0000_0001);
    while (lnk.vld !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    chk("link word", e, lnk.word);
    rreg(REG_DESC, d);
    chk("desc", e, d);
  endtask
  task t_addressed;
    logic [31:0] d;
    present <= 1'b1; inverted <= 1'b1; addressed <= 1'b1; byte1 <= 1'b1;
    aw <= RSND_AW32; bit_pos <= 3'h5; local_addr <= 8'hA5;
    rd_op <= 8'h3C; wr_op <= 8'h00;
    fetch(32'hDDA5_3C00);
    wreg(REG_CTRL, 32'h0000_0002);
    rreg(REG_ACCESS, d);
    chk("access", 32'h0000_00DF, d & 32'h0000_03FF);
    rreg(REG_CADDR, d);
    chk("caddr", 32'h0000_A500, d);
    wreg(REG_DESC, 32'hFFFF_FFFF);
    rreg(REG_DESC, d);
    chk("desc read only", 32'hDDA5_3C00, d);
  endtask
  task t_direct;
    logic [31:0] d;
    @(posedge mclk);
    present <= 1'b0; inverted <= 1'b0; addressed <= 1'b0; byte1 <= 1'b1;
    aw <= RSND_AW8; bit_pos <= 3'h2; mode_flags <= 4'hA; dummy <= 4'hF;
    rd_op <= 8'h11; wr_op <= 8'h22;
    fetch(32'h02AF_1122);
    wreg(REG_CTRL, 32'h0000_0010);
    rreg(REG_ACCESS, d);
    chk("access 8d", 32'h007F_E820, d);
    wreg(REG_CTRL, 32'h0000_0000);
    rreg(REG_ACCESS, d);
    chk("access 1s", 32'h0043_E820, d);
    wreg(REG_CTRL, 32'h0000_0004);
    rreg(REG_ACCESS, d);
    chk("access 4s", 32'h003F_E820, d);
    rreg(REG_CADDR, d);
    chk("caddr direct", 32'h0000_0000, d);
    rreg(REG_CTRL, d);
    chk("ctrl status", 32'h0000_0022, d);
  endtask
  task t_rate;
    logic [31:0] e;
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      nv_sel <= i[0]; inverted <= i[1]; dummy <= 4'h9;
      cmd_mode <= rsnd_mode_t'(i / 2);
      @(posedge mclk);
      @(negedge mclk);
      e = (i < 2) ? 32'h0000_0000 : 32'h0000_0009;
      chk("rate", 32'(i[0] ^ i[1]), 32'(double_rate));
      chk("dummy_used", e, 32'(dummy_used));
    end
  endtask
  // Low clock enable must hold double_rate and dummy_used although inputs move
  task t_freeze;
    @(posedge mclk);
    ce <= 1'b0; nv_sel <= 1'b0; inverted <= 1'b0;
    cmd_mode <= RSND_M8D; dummy <= 4'h6;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("frozen rate", 32'h0000_0001, 32'(double_rate));
    chk("frozen dummy", 32'h0000_0009, 32'(dummy_used));
    @(posedge mclk);
    ce <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk("thawed rate", 32'h0000_0000, 32'(double_rate));
    chk("thawed dummy", 32'h0000_0006, 32'(dummy_used));
  endtask
  initial begin
    reset = 1'b1; present = 1'b0; inverted = 1'b0; addressed = 1'b0;
    byte1 = 1'b0; aw = RSND_AW24; bit_pos = 3'h0; local_addr = 8'h00;
    mode_flags = 4'h0; dummy = 4'h0; rd_op = 8'h00; wr_op = 8'h00;
    nv_sel = 1'b0; cmd_mode = RSND_M1S; addr = 2'h0; wdata = ZERO32;
    wr = 1'b0; rd = 1'b0; ce = 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    t_addressed;
    t_direct;
    t_rate;
    t_freeze;
    final_report;
  end
endmodule // rate_select_nv_descriptor_tb
